// ==== design/urx_rx_path.sv ====
/*
 * Receive FIFO, status, flow control, loop modes and multidrop tag
 * handling of one asynchronous serial channel.
 * Assumes a separate bit engine that reports start bits and finished
 * characters as one-cycle pulses, and a transmitter beside it.
 */
`include "urx_regs.svh"
module urx_rx_path
	import urx_pkg::*;
#(
	parameter int DEPTH = 16
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [`URX_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rx_start_seen,
	input wire logic rx_char_done,
	input wire logic [7:0] rx_char_data,
	input wire logic rx_char_parity_err,
	input wire logic rx_char_tag,
	input wire logic rx_char_frame_err,
	input wire logic rx_char_break,
	output logic rx_engine_enable,
	output logic rx_serial_to_engine,
	input wire logic rxd_pin,
	input wire logic tx_engine_out,
	output logic txd_pin,
	input wire logic [7:0] tx_wdata,
	input wire logic tx_wr,
	output logic tx_load,
	output logic [7:0] tx_load_data,
	output logic tx_load_tag,
	output logic general_output_zero_n,
	output logic rx_irq_req
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	localparam int PW = $clog2(DEPTH);

	generate
		if (DEPTH != 8 && DEPTH != 16)
		begin
			$error("urx_rx_path: DEPTH must be 8 or 16");
		end
	endgenerate

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] mode_one_q;
	logic [7:0] mode_two_q;
	logic rx_enabled_q;
	logic overrun_q;
	logic [2:0] block_flags_q;
	logic hold_valid_q;
	urx_entry_s hold_q;
	logic rts_active_q;
	logic rts_held_off_q;
	logic txd_q;
	logic [7:0] rdata_q;
	logic tx_load_q;
	logic [7:0] tx_load_data_q;
	logic tx_load_tag_q;
	urx_entry_s fifo_mem [DEPTH];
	logic [PW:0] wr_ptr_q;
	logic [PW:0] rd_ptr_q;

	logic wr_mode_one;
	logic wr_mode_two;
	logic wr_command;
	logic rd_buffer;
	logic [3:0] cmd_code;
	logic rx_reset_cmd;
	logic err_reset_cmd;
	logic enable_cmd;
	logic disable_cmd;
	logic multidrop;
	urx_loop_e loop_mode;
	logic fifo_empty;
	logic fifo_full;
	logic pop;
	logic space;
	urx_entry_s new_entry;
	logic new_ok;
	logic push;
	urx_entry_s push_entry;
	logic hold_load;
	urx_entry_s head;
	logic [7:0] data_mask;
	logic [7:0] status;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	assign wr_mode_one = reg_wr && reg_addr == `URX_OFS_MODE_ONE;
	assign wr_mode_two = reg_wr && reg_addr == `URX_OFS_MODE_TWO;
	assign wr_command = reg_wr && reg_addr == `URX_OFS_COMMAND;
	assign rd_buffer = reg_rd && reg_addr == `URX_OFS_BUFFER;
	assign cmd_code = reg_wdata[7:4];
	assign rx_reset_cmd = wr_command && cmd_code == `URX_CMD_RESET_RX;
	assign err_reset_cmd = wr_command && cmd_code == `URX_CMD_RESET_ERR;
	assign enable_cmd = wr_command && reg_wdata[1:0] == `URX_RX_ENABLE_CODE;
	assign disable_cmd = wr_command && reg_wdata[1:0] == `URX_RX_DISABLE_CODE;
	assign multidrop = mode_one_q[`URX_MR1_PAR_HI:`URX_MR1_PAR_LO] == `URX_PAR_MULTIDROP;
	assign loop_mode = urx_loop_e'(mode_two_q[`URX_MR2_LOOP_HI:`URX_MR2_LOOP_LO]);

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			mode_one_q <= `URX_MR1_RESET;
		else if (wr_mode_one)
			mode_one_q <= reg_wdata;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			mode_two_q <= `URX_MR2_RESET;
		else if (wr_mode_two)
			mode_two_q <= reg_wdata;
	end

	// ----------------------------------------
	// Receiver enable
	// ----------------------------------------
	// Reset needs a fresh enable, even if the same write carries one
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rx_enabled_q <= 1'b0;
		else if (rx_reset_cmd || disable_cmd)
			rx_enabled_q <= 1'b0;
		else if (enable_cmd)
			rx_enabled_q <= 1'b1;
	end

	// Multidrop keeps the engine watching while disabled
	assign rx_engine_enable = rx_enabled_q || multidrop;

	// ----------------------------------------
	// Incoming character
	// ----------------------------------------
	always_comb
	begin
		case (mode_one_q[`URX_MR1_LEN_HI:`URX_MR1_LEN_LO])
			2'h0: data_mask = 8'h1F;
			2'h1: data_mask = 8'h3F;
			2'h2: data_mask = 8'h7F;
			default: data_mask = 8'hFF;
		endcase
	end

	always_comb
	begin
		new_entry.data = rx_char_data & data_mask;
		new_entry.par_tag = multidrop ? rx_char_tag : rx_char_parity_err;
		new_entry.frame = rx_char_frame_err;
		new_entry.brk = rx_char_break;
	end

	// Remote loopback cuts the CPU off from received data
	assign new_ok = rx_char_done && loop_mode != URX_LOOP_REMOTE &&
		(rx_enabled_q || (multidrop && rx_char_tag));

	// ----------------------------------------
	// FIFO
	// ----------------------------------------
	assign fifo_empty = wr_ptr_q == rd_ptr_q;
	assign fifo_full = wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0] && wr_ptr_q[PW] != rd_ptr_q[PW];
	assign pop = rd_buffer && !fifo_empty;
	assign space = !fifo_full || pop;
	assign head = fifo_mem[rd_ptr_q[PW-1:0]];

	// Held character has priority: it is older than anything new
	always_comb
	begin
		push = 1'b0;
		hold_load = 1'b0;
		push_entry = new_entry;
		if (!rx_reset_cmd)
		begin
			if (hold_valid_q && space)
			begin
				push = 1'b1;
				push_entry = hold_q;
			end
			else if (new_ok && space && !hold_valid_q)
				push = 1'b1;
			else if (new_ok)
				hold_load = 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (push)
			fifo_mem[wr_ptr_q[PW-1:0]] <= push_entry;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			wr_ptr_q <= '0;
		else if (rx_reset_cmd)
			wr_ptr_q <= '0;
		else if (push)
			wr_ptr_q <= wr_ptr_q + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_ptr_q <= '0;
		else if (rx_reset_cmd)
			rd_ptr_q <= '0;
		else if (pop)
			rd_ptr_q <= rd_ptr_q + 1'b1;
	end

	// ----------------------------------------
	// Shift register hold and overrun
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			hold_valid_q <= 1'b0;
		else if (rx_reset_cmd || disable_cmd)
			hold_valid_q <= 1'b0;
		else if (hold_load)
			hold_valid_q <= 1'b1;
		else if (hold_valid_q && space)
			hold_valid_q <= 1'b0;
		else if (rx_start_seen && hold_valid_q)
			hold_valid_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			hold_q <= '0;
		else if (hold_load)
			hold_q <= new_entry;
	end

	// Set wins over the reset-error clear
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			overrun_q <= 1'b0;
		else if (rx_start_seen && hold_valid_q && !space)
			overrun_q <= 1'b1;
		else if (rx_reset_cmd || err_reset_cmd)
			overrun_q <= 1'b0;
	end

	// ----------------------------------------
	// Block mode accumulation
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			block_flags_q <= 3'h0;
		else if (rx_reset_cmd)
			block_flags_q <= 3'h0;
		else
			block_flags_q <= (err_reset_cmd ? 3'h0 : block_flags_q) |
				(push ? {push_entry.brk, push_entry.frame, push_entry.par_tag} : 3'h0);
	end

	// ----------------------------------------
	// Status
	// ----------------------------------------
	// Character mode flags are meaningless on an empty FIFO, so show zero
	always_comb
	begin
		status = 8'h00;
		status[`URX_SR_READY_BIT] = !fifo_empty;
		status[`URX_SR_FULL_BIT] = fifo_full;
		status[`URX_SR_OVERRUN_BIT] = overrun_q;
		if (mode_one_q[`URX_MR1_ERR_MODE_BIT])
		begin
			status[`URX_SR_PARITY_BIT] = block_flags_q[0];
			status[`URX_SR_FRAME_BIT] = block_flags_q[1];
			status[`URX_SR_BREAK_BIT] = block_flags_q[2];
		end
		else if (!fifo_empty)
		begin
			status[`URX_SR_PARITY_BIT] = head.par_tag;
			status[`URX_SR_FRAME_BIT] = head.frame;
			status[`URX_SR_BREAK_BIT] = head.brk;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_q <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`URX_OFS_MODE_ONE: rdata_q <= mode_one_q;
				`URX_OFS_MODE_TWO: rdata_q <= mode_two_q;
				`URX_OFS_STATUS: rdata_q <= status;
				`URX_OFS_BUFFER: rdata_q <= fifo_empty ? 8'h00 : head.data;
				default: rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= 8'h00;
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// Receiver flow control
	// ----------------------------------------
	// Manual assert needed first; afterwards the receiver steers it
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rts_active_q <= 1'b0;
		else if (rx_reset_cmd)
			rts_active_q <= 1'b0;
		else if (wr_command && cmd_code == `URX_CMD_ASSERT_RTS)
			rts_active_q <= 1'b1;
		else if (wr_command && cmd_code == `URX_CMD_NEGATE_RTS)
			rts_active_q <= 1'b0;
		else if (mode_one_q[`URX_MR1_FLOW_BIT] && rx_start_seen && fifo_full && !pop)
			rts_active_q <= 1'b0;
		else if (rts_held_off_q && !fifo_full)
			rts_active_q <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rts_held_off_q <= 1'b0;
		else if (rx_reset_cmd || !mode_one_q[`URX_MR1_FLOW_BIT])
			rts_held_off_q <= 1'b0;
		else if (rx_start_seen && fifo_full && !pop && rts_active_q)
			rts_held_off_q <= 1'b1;
		else if (!fifo_full)
			rts_held_off_q <= 1'b0;
	end

	assign general_output_zero_n = !rts_active_q;

	// ----------------------------------------
	// Receive interrupt request
	// ----------------------------------------
	// Cleared with the FIFO on receiver reset
	assign rx_irq_req = mode_one_q[`URX_MR1_IRQ_SEL_BIT] ? fifo_full : !fifo_empty;

	// ----------------------------------------
	// Loop modes
	// ----------------------------------------
	assign rx_serial_to_engine = loop_mode == URX_LOOP_LOCAL ? tx_engine_out : rxd_pin;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			txd_q <= 1'b1;
		else
		begin
			case (loop_mode)
				URX_LOOP_ECHO: txd_q <= rxd_pin;
				URX_LOOP_REMOTE: txd_q <= rxd_pin;
				URX_LOOP_LOCAL: txd_q <= 1'b1;
				default: txd_q <= tx_engine_out;
			endcase
		end
	end

	assign txd_pin = txd_q;

	// ----------------------------------------
	// Transmit load with tag
	// ----------------------------------------
	// Tag sampled per character, so the mode bit may change at once
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			tx_load_q <= 1'b0;
		else
			tx_load_q <= tx_wr && loop_mode != URX_LOOP_ECHO && loop_mode != URX_LOOP_REMOTE;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_load_data_q <= 8'h00;
			tx_load_tag_q <= 1'b0;
		end
		else if (tx_wr)
		begin
			tx_load_data_q <= tx_wdata;
			tx_load_tag_q <= multidrop && mode_one_q[`URX_MR1_TAG_BIT];
		end
	end

	assign tx_load = tx_load_q;
	assign tx_load_data = tx_load_data_q;
	assign tx_load_tag = tx_load_tag_q;

endmodule

// ==== design/urx_regs.svh ====
/*
 * Register offsets, field positions, reset values and command codes
 * of the receive path of one serial channel.
 * Assumes inclusion by bare name from the package and the design module.
 */
// Functional notes
// - Error flags set at character end, valid with ready
// - Status bit 0 set while FIFO holds data
// - Buffer read returns oldest entry, then pops it
// - Status bit 1 set when FIFO is full
// - Mode one bit 6 picks interrupt condition
// - Entries hold parity, framing, break; not overrun
// - Character mode shows head entry flags only
// - Block mode ORs flags until reset-error command
// - Status read never disturbs the FIFO
// - Character on full FIFO waits in shift register
// - Next start bit drops held character, sets overrun
// - Flow control negates RTS on a start bit while full, reasserts later
// - Disabled receiver keeps FIFO readable, drops pending character
// - Receiver reset clears FIFO, flags, RTS, interrupt; a same-cycle overrun set wins
// - Mode two bits 7:6 choose loop; echo blocks transmit
// - Local loopback feeds transmitter to receiver, pin marks
// - Remote loopback echoes bits, blocks both CPU paths
// - Parity mode 11 is multidrop; tag replaces parity
// - Transmit tag follows mode one bit 2 per character
// - Disabled multidrop receiver queues only address characters
// - Received tag stored in parity slot, status bit 5
// - Short characters get zero upper data bits
`ifndef URX_REGS_SVH
`define URX_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define URX_ADDR_W 3
`define URX_OFS_MODE_ONE 3'h0
`define URX_OFS_MODE_TWO 3'h1
`define URX_OFS_STATUS 3'h2
`define URX_OFS_COMMAND 3'h3
`define URX_OFS_BUFFER 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define URX_MR1_FLOW_BIT 7
`define URX_MR1_IRQ_SEL_BIT 6
`define URX_MR1_ERR_MODE_BIT 5
`define URX_MR1_PAR_HI 4
`define URX_MR1_PAR_LO 3
`define URX_MR1_TAG_BIT 2
`define URX_MR1_LEN_HI 1
`define URX_MR1_LEN_LO 0
`define URX_MR2_LOOP_HI 7
`define URX_MR2_LOOP_LO 6
`define URX_SR_READY_BIT 0
`define URX_SR_FULL_BIT 1
`define URX_SR_OVERRUN_BIT 4
`define URX_SR_PARITY_BIT 5
`define URX_SR_FRAME_BIT 6
`define URX_SR_BREAK_BIT 7

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define URX_MR1_RESET 8'h00
`define URX_MR2_RESET 8'h00
`define URX_PAR_MULTIDROP 2'h3
`define URX_RX_ENABLE_CODE 2'h1
`define URX_RX_DISABLE_CODE 2'h2
`define URX_CMD_RESET_RX 4'h2
`define URX_CMD_RESET_ERR 4'h4
`define URX_CMD_ASSERT_RTS 4'h8
`define URX_CMD_NEGATE_RTS 4'h9

`endif

// ==== design/urx_pkg.sv ====
/*
 * Types shared by the receive path.
 * Assumes urx_regs.svh is on the include path.
 */
`include "urx_regs.svh"
package urx_pkg;
	typedef enum logic [1:0]
	{
		URX_LOOP_NORMAL,
		URX_LOOP_ECHO,
		URX_LOOP_LOCAL,
		URX_LOOP_REMOTE
	} urx_loop_e;

	typedef struct packed
	{
		logic brk;
		logic frame;
		logic par_tag;
		logic [7:0] data;
	} urx_entry_s;
endpackage

// ==== bench/urx_rx_path_checker.sv ====
/* Port assertions for the receive path.
   Assumes one clock and one-cycle register strobes. */
`include "urx_regs.svh"
module urx_rx_path_checker
	import urx_pkg::*;
#(
	parameter int DEPTH = 16
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [`URX_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic rxd_pin,
	input wire logic tx_engine_out,
	input wire logic txd_pin,
	input wire logic [7:0] tx_wdata,
	input wire logic tx_wr,
	input wire logic tx_load,
	input wire logic [7:0] tx_load_data,
	input wire logic tx_load_tag,
	input wire logic rx_engine_enable,
	input wire logic rx_serial_to_engine,
	input wire logic general_output_zero_n,
	input wire logic rx_irq_req
);
timeunit 1ns;
timeprecision 1ns;
// ----------------------------------------
// Shadow of modes and enable
// ----------------------------------------
logic [7:0] mr1_q;
logic [1:0] loop_q;
logic en_q, cmd_w, md, ech, loc, tag_c;
assign cmd_w = reg_wr && reg_addr == `URX_OFS_COMMAND;
assign md = mr1_q[4:3] == `URX_PAR_MULTIDROP;
assign ech = loop_q[0];
assign loc = loop_q == 2'h2;
assign tag_c = md && mr1_q[`URX_MR1_TAG_BIT];
always_ff @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
		mr1_q <= `URX_MR1_RESET;
	else if (reg_wr && reg_addr == `URX_OFS_MODE_ONE)
		mr1_q <= reg_wdata;
end
always_ff @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
		loop_q <= 2'h0;
	else if (reg_wr && reg_addr == `URX_OFS_MODE_TWO)
		loop_q <= reg_wdata[7:6];
end
// Reset command wins over a same-write enable
always_ff @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
		en_q <= 1'b0;
	else if (cmd_w && reg_wdata[7:4] == `URX_CMD_RESET_RX)
		en_q <= 1'b0;
	else if (cmd_w && reg_wdata[1:0] == `URX_RX_ENABLE_CODE)
		en_q <= 1'b1;
	else if (cmd_w && reg_wdata[1:0] == `URX_RX_DISABLE_CODE)
		en_q <= 1'b0;
end
// ----------------------------------------
// Assertions
// ----------------------------------------
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!reset_n);
sequence s_rx_reset;
	cmd_w && reg_wdata[7:4] == `URX_CMD_RESET_RX;
endsequence
sequence s_rts_cmd;
	cmd_w && reg_wdata[7:5] == 3'h4;
endsequence
a_rx_reset_clears: assert property (s_rx_reset |=> general_output_zero_n && !rx_irq_req)
	else $error("rx reset left rts or irq");
a_rts_manual: assert property (s_rts_cmd |=> general_output_zero_n == $past(reg_wdata[4]))
	else $error("rts command ignored");
a_tx_blocked: assert property (tx_wr && ech |=> !tx_load)
	else $error("cpu transmit not blocked");
a_tx_passes: assert property (tx_wr && !ech |=> tx_load && tx_load_data == $past(tx_wdata))
	else $error("cpu transmit lost");
a_tag_follows: assert property (tx_wr |=> tx_load_tag == $past(tag_c))
	else $error("transmit tag wrong");
a_echo_bits: assert property ($past(ech) |-> txd_pin == $past(rxd_pin))
	else $error("echo bit wrong");
a_local_mark: assert property ($past(loc) |-> txd_pin)
	else $error("tx pin not at mark");
a_local_feed: assert property (loc |-> rx_serial_to_engine == tx_engine_out)
	else $error("local loop not fed");
a_engine_on: assert property (rx_engine_enable == (en_q || md))
	else $error("engine enable wrong");
endmodule
bind urx_rx_path urx_rx_path_checker #(.DEPTH(DEPTH)) urx_rx_path_checker_inst (
	.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .rxd_pin(rxd_pin), .tx_engine_out(tx_engine_out), .txd_pin(txd_pin),
	.tx_wdata(tx_wdata), .tx_wr(tx_wr), .tx_load(tx_load), .tx_load_data(tx_load_data),
	.tx_load_tag(tx_load_tag), .rx_engine_enable(rx_engine_enable),
	.rx_serial_to_engine(rx_serial_to_engine),
	.general_output_zero_n(general_output_zero_n), .rx_irq_req(rx_irq_req));

// ==== bench/urx_remote_station.sv ====
/* Remote station as seen through the bit engine pulses.
   Assumes the bench calls send from one thread. */
module urx_remote_station
(
	input wire logic sys_clk,
	output logic rxd_pin,
	output logic start_seen,
	output logic char_done,
	output logic [7:0] data,
	output logic [3:0] flags
);
timeunit 1ns;
timeprecision 1ns;
logic busy;
initial
begin
	busy = 1'b0;
	start_seen = 1'b0;
	char_done = 1'b0;
	data = 8'h00;
	flags = 4'h0;
end
// Line idles at mark, toggles within a frame
always @(posedge sys_clk)
	rxd_pin <= busy ? ~rxd_pin : 1'b1;
// Flags {break, framing, tag, parity}; fin low stops after the start bit
task send(input logic [7:0] d, input logic [3:0] f, input bit fin, input int gap);
	@(posedge sys_clk);
	busy <= 1'b1;
	start_seen <= 1'b1;
	@(posedge sys_clk);
	start_seen <= 1'b0;
	repeat (gap) @(posedge sys_clk);
	char_done <= fin;
	data <= d;
	flags <= f;
	@(posedge sys_clk);
	char_done <= 1'b0;
	busy <= 1'b0;
	data <= ~d;
	flags <= ~f;
endtask
endmodule

// ==== bench/tb_urx_rx_path.sv ====
/* Self-checking bench for the receive path.
   Assumes the station model and checker bind are compiled first. */
`include "urx_regs.svh"
module tb_urx_rx_path
	import urx_pkg::*;
;
timeunit 1ns;
timeprecision 1ns;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
logic sys_clk, reset_n, reg_wr, reg_rd, tx_wr, tx_eng, txd, tx_load, tl_tag, rts_n, irq;
logic eng_en, ser, rxd, st, dn;
logic [`URX_ADDR_W-1:0] reg_addr;
logic [7:0] reg_wdata, reg_rdata, tx_wdata, tld, cd;
logic [3:0] cf;
int fails, n_checks;
urx_rx_path #(.DEPTH(8)) urx_rx_path_inst (.sys_clk(sys_clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rx_start_seen(st), .rx_char_done(dn), .rx_char_data(cd),
	.rx_char_parity_err(cf[0]), .rx_char_tag(cf[1]), .rx_char_frame_err(cf[2]),
	.rx_char_break(cf[3]), .rx_engine_enable(eng_en), .rx_serial_to_engine(ser),
	.rxd_pin(rxd), .tx_engine_out(tx_eng), .txd_pin(txd), .tx_wdata(tx_wdata),
	.tx_wr(tx_wr), .tx_load(tx_load), .tx_load_data(tld), .tx_load_tag(tl_tag),
	.general_output_zero_n(rts_n), .rx_irq_req(irq));
urx_remote_station urx_remote_station_inst (.sys_clk(sys_clk), .rxd_pin(rxd),
	.start_seen(st), .char_done(dn), .data(cd), .flags(cf));
initial
begin
	sys_clk = 1'b0;
	forever #25 sys_clk = ~sys_clk;
end
always @(posedge sys_clk)
	tx_eng <= ~tx_eng;
task tally_and_finish;
	$display("checks %0d mismatches %0d", n_checks, fails);
	if (fails == 0 && n_checks > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
task wr(input logic [2:0] a, input logic [7:0] d);
	@(posedge sys_clk);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge sys_clk);
	reg_wr <= 1'b0;
endtask
task rd(input logic [2:0] a, input logic [7:0] e);
	@(posedge sys_clk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge sys_clk);
	reg_rd <= 1'b0;
	#1;
	`CHK(reg_rdata, e)
endtask
task snd(input logic [7:0] d, input logic [3:0] f, input bit fin);
	urx_remote_station_inst.send(d, f, fin, 3);
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task t_fifo;
	wr(`URX_OFS_MODE_ONE, 8'h03);
	wr(`URX_OFS_COMMAND, 8'h01);
	for (int i = 0; i < 8; i++)
		snd(8'h10 + 8'(i), (i == 0) ? 4'h1 : 4'h0, 1'b1);
	rd(`URX_OFS_STATUS, 8'h23);
	snd(8'hA9, 4'h0, 1'b1);
	snd(8'hAA, 4'h0, 1'b1);
	rd(`URX_OFS_STATUS, 8'h33);
	for (int i = 0; i < 8; i++)
		rd(`URX_OFS_BUFFER, 8'h10 + 8'(i));
	rd(`URX_OFS_BUFFER, 8'hAA);
	rd(`URX_OFS_BUFFER, 8'h00);
	wr(`URX_OFS_COMMAND, 8'h40);
	rd(`URX_OFS_STATUS, 8'h00);
endtask
task t_block;
	wr(`URX_OFS_MODE_ONE, 8'h20);
	snd(8'hFF, 4'h4, 1'b1);
	snd(8'hE0, 4'h0, 1'b1);
	rd(`URX_OFS_STATUS, 8'h41);
	`CHK(irq, 1'b1)
	rd(`URX_OFS_BUFFER, 8'h1F);
	rd(`URX_OFS_BUFFER, 8'h00);
	rd(`URX_OFS_STATUS, 8'h40);
	wr(`URX_OFS_COMMAND, 8'h40);
	rd(`URX_OFS_STATUS, 8'h00);
endtask
// Start bit without a finished character keeps the FIFO below full after one pop
task t_flow;
	wr(`URX_OFS_MODE_ONE, 8'hC3);
	wr(`URX_OFS_COMMAND, 8'h80);
	for (int i = 0; i < 8; i++)
		snd(8'h20 + 8'(i), 4'h0, 1'b1);
	#1;
	`CHK(irq, 1'b1)
	snd(8'h55, 4'h0, 1'b0);
	`CHK(rts_n, 1'b1)
	rd(`URX_OFS_BUFFER, 8'h20);
	@(posedge sys_clk);
	#1;
	`CHK(rts_n, 1'b0)
	`CHK(irq, 1'b0)
	wr(`URX_OFS_COMMAND, 8'h90);
	#1;
	`CHK(rts_n, 1'b1)
	wr(`URX_OFS_COMMAND, 8'h20);
	rd(`URX_OFS_STATUS, 8'h00);
	rd(`URX_OFS_BUFFER, 8'h00);
endtask
task t_multidrop;
	wr(`URX_OFS_MODE_ONE, 8'h1A);
	snd(8'h55, 4'h0, 1'b1);
	snd(8'hA1, 4'h2, 1'b1);
	rd(`URX_OFS_STATUS, 8'h21);
	rd(`URX_OFS_BUFFER, 8'h21);
	wr(`URX_OFS_COMMAND, 8'h01);
	snd(8'h56, 4'h1, 1'b1);
	rd(`URX_OFS_STATUS, 8'h01);
	rd(`URX_OFS_BUFFER, 8'h56);
	wr(`URX_OFS_COMMAND, 8'h02);
	wr(`URX_OFS_MODE_ONE, 8'h03);
	snd(8'h77, 4'h0, 1'b1);
	rd(`URX_OFS_STATUS, 8'h00);
endtask
task t_loops;
	wr(`URX_OFS_COMMAND, 8'h01);
	for (int m = 0; m < 4; m++)
	begin
		wr(`URX_OFS_MODE_ONE, (m == 1) ? 8'h19 : 8'h1D);
		wr(`URX_OFS_MODE_TWO, 8'(m << 6));
		@(posedge sys_clk);
		tx_wdata <= 8'h5A + 8'(m);
		tx_wr <= 1'b1;
		@(posedge sys_clk);
		tx_wr <= 1'b0;
		#1;
		`CHK(tx_load, 1'(m % 2 == 0))
		`CHK(tl_tag, 1'(m != 1))
		`CHK(tld, 8'h5A + 8'(m))
		snd(8'h30 + 8'(m), 4'h2, 1'b1);
		rd(`URX_OFS_STATUS, (m == 3) ? 8'h00 : 8'h21);
		rd(`URX_OFS_BUFFER, (m == 3) ? 8'h00 : 8'h30 + 8'(m));
	end
	wr(`URX_OFS_MODE_TWO, 8'h00);
endtask
initial
begin
	repeat (20000) @(posedge sys_clk);
	fails++;
	$display("CHECK FAILED t=%0t timeout", $time);
	tally_and_finish;
end
initial
begin
	fails = 0;
	n_checks = 0;
	reset_n = 1'b0;
	reg_wr = 1'b0;
	reg_rd = 1'b0;
	reg_addr = '0;
	reg_wdata = 8'h00;
	tx_wr = 1'b0;
	tx_wdata = 8'h00;
	tx_eng = 1'b1;
	repeat (10) @(posedge sys_clk);
	reset_n <= 1'b1;
	t_fifo;
	t_block;
	t_flow;
	t_multidrop;
	t_loops;
	tally_and_finish;
end
endmodule
